// ===== hw/uic_regs.sv
// Register-level universal interrupt controller with vector generation.
//
// Operation
// - Status bits 5-8 latch DMA 0-3 interrupts; 4, 9-16, 18-24 reserved.
// - Status bit 17 latches the correctable memory error interrupt.
// - Status bits 25-31 latch external request lines 0-6.
// - Trigger register at 0x0c5: bit 0 selects level, 1 selects edge.
// - External lines 0-6 may be set to level or edge freely.
// - Write-only setup at 0x0c8: base in bits 0:29, order bit 31.
// - Vectors are generated for critical sources only.
// - Read-only vector register at 0x0c7 ignores writes.
// - Class bit routes a source to non-critical (0) or critical (1).
// - Enable bit 0 blocks a source, 1 lets it signal the core.
`default_nettype none
`include "uic_params.svh"
module uic_regs (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [`UIC_ADDR_W-1:0] i_dcr_addr,
    input wire logic i_dcr_read,
    input wire logic i_dcr_write,
    input wire logic [0:31] i_dcr_wdata,
    input wire logic [0:8] i_periph_irq,
    input wire logic i_ecc_irq,
    input wire logic [0:6] i_ext_irq,
    output logic [0:31] o_dcr_rdata,
    output logic o_dcr_ack,
    output logic o_crit_int,
    output logic o_noncrit_int
);
    uic_pkg::uic_state_t st_ff;
    uic_pkg::uic_state_t nxt_st;
    logic [0:6] ext_sync;
    logic [0:31] raw;
    logic [0:31] hit;
    logic [0:31] clr;
    logic [0:31] masked;
    logic [0:31] cand;
    logic [4:0] pos;
    logic found;

    // Pins cross into the core clock before any logic looks at them.
    uic_sync #(.W(`UIC_SYNC_W)) u_sync (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_async(i_ext_irq),
        .o_sync(ext_sync)
    );

    always_comb begin
        raw = '0;
        raw[0:8] = i_periph_irq;
        raw[`UIC_POS_ECC] = i_ecc_irq;
        raw[`UIC_POS_EXT0:31] = ext_sync;
        raw = raw & `UIC_VALID_MASK;
    end

    always_comb begin
        nxt_st = st_ff;
        clr = '0;
        // An edge source sets on a rising input, a level source while high.
        hit = (st_ff.trig_ff & raw & ~st_ff.prev_ff)
            | (~st_ff.trig_ff & raw);
        if (i_dcr_write && i_dcr_addr == `UIC_OFS_STATUS) begin
            clr = i_dcr_wdata;
        end
        // Set wins over a software clear in the same cycle.
        nxt_st.status_ff = ((st_ff.status_ff & ~clr) | hit)
            & `UIC_VALID_MASK;
        nxt_st.prev_ff = raw;
        masked = st_ff.status_ff & st_ff.enable_ff;
        cand = masked & st_ff.class_ff;
        nxt_st.crit_ff = |cand;
        nxt_st.noncrit_ff = |(masked & ~st_ff.class_ff);
        pos = 5'h00;
        found = 1'b0;
        for (int i = 0; i < 32; i++) begin
            if (cand[i] && (!found || st_ff.dir_ff)) begin
                pos = 5'(i);
                found = 1'b1;
            end
        end
        // Non-critical sources never form a vector.
        if (found) begin
            nxt_st.vec_ff = {st_ff.base_ff, 2'h0}
                + {18'h0, pos, 9'h000};
        end else begin
            nxt_st.vec_ff = '0;
        end
        if (i_dcr_write) begin
            unique case (i_dcr_addr)
                `UIC_OFS_ENABLE: nxt_st.enable_ff =
                    i_dcr_wdata & `UIC_VALID_MASK;
                `UIC_OFS_CLASS: nxt_st.class_ff =
                    i_dcr_wdata & `UIC_VALID_MASK;
                `UIC_OFS_TRIGGER: nxt_st.trig_ff =
                    i_dcr_wdata & `UIC_VALID_MASK;
                `UIC_OFS_VSETUP: begin
                    nxt_st.base_ff = i_dcr_wdata[0:29];
                    nxt_st.dir_ff = i_dcr_wdata[`UIC_POS_DIR];
                end
                default: ;
            endcase
        end
        nxt_st.ack_ff = i_dcr_read || i_dcr_write;
        nxt_st.rdata_ff = '0;
        if (i_dcr_read) begin
            unique case (i_dcr_addr)
                `UIC_OFS_STATUS: nxt_st.rdata_ff = st_ff.status_ff;
                `UIC_OFS_ENABLE: nxt_st.rdata_ff = st_ff.enable_ff;
                `UIC_OFS_CLASS: nxt_st.rdata_ff = st_ff.class_ff;
                `UIC_OFS_TRIGGER: nxt_st.rdata_ff = st_ff.trig_ff;
                `UIC_OFS_MASKED: nxt_st.rdata_ff = masked;
                `UIC_OFS_VECTOR: nxt_st.rdata_ff = st_ff.vec_ff;
                default: nxt_st.rdata_ff = '0;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_dcr_rdata = st_ff.rdata_ff;
    assign o_dcr_ack = st_ff.ack_ff;
    assign o_crit_int = st_ff.crit_ff;
    assign o_noncrit_int = st_ff.noncrit_ff;

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);

    a_dma_level_set: assert property (
        !st_ff.trig_ff[`UIC_POS_DMA0] && raw[`UIC_POS_DMA0]
        |=> st_ff.status_ff[`UIC_POS_DMA0])
        else $error("DMA level did not set status.");
    a_reserved_zero: assert property (
        (st_ff.status_ff & ~`UIC_VALID_MASK) == '0)
        else $error("Reserved status bit set.");
    a_ecc_level_set: assert property (
        !st_ff.trig_ff[`UIC_POS_ECC] && i_ecc_irq
        |=> st_ff.status_ff[`UIC_POS_ECC])
        else $error("Correctable error did not set status.");
    a_ext_rise_cause: assert property (
        $rose(st_ff.status_ff[`UIC_POS_EXT0]) |-> $past(ext_sync[0]))
        else $error("External status rose without a request.");
    a_edge_no_set: assert property (
        st_ff.trig_ff[`UIC_POS_EXT0] && !st_ff.status_ff[`UIC_POS_EXT0]
        && raw[`UIC_POS_EXT0] && st_ff.prev_ff[`UIC_POS_EXT0]
        |=> !st_ff.status_ff[`UIC_POS_EXT0])
        else $error("Edge source set on a steady level.");
    a_vsetup_reads_zero: assert property (
        i_dcr_read && i_dcr_addr == `UIC_OFS_VSETUP
        |=> o_dcr_ack && o_dcr_rdata == '0)
        else $error("Vector setup was readable.");
    a_prio_order_low: assert property (
        cand[`UIC_POS_EXT0] && cand[31] && (cand[0:24] == '0)
        && !st_ff.dir_ff
        |=> st_ff.vec_ff == {$past(st_ff.base_ff), 2'h0}
            + 32'h0000_3200)
        else $error("Wrong vector for ascending priority.");
    a_noncrit_novec: assert property (
        cand == '0 |=> st_ff.vec_ff == '0)
        else $error("Vector formed without a critical source.");
    a_vector_ro: assert property (
        i_dcr_write && i_dcr_addr == `UIC_OFS_VECTOR
        |=> $stable(st_ff.trig_ff) && $stable(st_ff.base_ff)
            && $stable(st_ff.enable_ff))
        else $error("Write to vector register changed state.");
    a_class_route: assert property (
        (masked & ~st_ff.class_ff) != '0 |=> o_noncrit_int)
        else $error("Non-critical source not routed.");
    a_enable_block: assert property (
        st_ff.enable_ff == '0 |=> !o_crit_int && !o_noncrit_int)
        else $error("Disabled source reached the core.");
    // A clear must win whenever the source is quiet, or software could
    // never acknowledge a channel that has already dropped its request.
    a_dma_clear: assert property (
        i_dcr_write && i_dcr_addr == `UIC_OFS_STATUS
        && i_dcr_wdata[`UIC_POS_DMA0] && !raw[`UIC_POS_DMA0]
        |=> !st_ff.status_ff[`UIC_POS_DMA0])
        else $error("DMA status survived a clear.");
    a_ext_level_set: assert property (
        !st_ff.trig_ff[`UIC_POS_EXT0 + 1] && raw[`UIC_POS_EXT0 + 1]
        |=> st_ff.status_ff[`UIC_POS_EXT0 + 1])
        else $error("External level line did not set status.");
    a_crit_route: assert property (
        cand != '0 |=> o_crit_int)
        else $error("Critical source not routed.");
    a_prio_order_high: assert property (
        st_ff.dir_ff && cand[6] && cand[7] && (cand[8:31] == '0)
        |=> st_ff.vec_ff == {$past(st_ff.base_ff), 2'h0}
            + 32'h0000_0e00)
        else $error("Wrong vector for descending priority.");
    a_trig_write: assert property (
        i_dcr_write && i_dcr_addr == `UIC_OFS_TRIGGER
        |=> st_ff.trig_ff == ($past(i_dcr_wdata) & `UIC_VALID_MASK))
        else $error("Trigger register did not take the write.");
    a_vsetup_write: assert property (
        i_dcr_write && i_dcr_addr == `UIC_OFS_VSETUP
        |=> st_ff.base_ff == $past(i_dcr_wdata[0:29])
            && st_ff.dir_ff == $past(i_dcr_wdata[`UIC_POS_DIR]))
        else $error("Vector setup did not take the write.");

    c_crit_raised: cover property ($rose(o_crit_int));
    c_noncrit_raised: cover property ($rose(o_noncrit_int));
    c_status_clear: cover property (
        i_dcr_write && i_dcr_addr == `UIC_OFS_STATUS);
    c_high_first: cover property (st_ff.dir_ff && st_ff.crit_ff);
    c_edge_held: cover property (st_ff.trig_ff[`UIC_POS_EXT0]
        && raw[`UIC_POS_EXT0] && st_ff.prev_ff[`UIC_POS_EXT0]);
endmodule
`default_nettype wire

// ===== hw/uic_params.svh
// Register offsets, field positions, reset values and constants of the UIC.
`ifndef UIC_PARAMS_SVH
`define UIC_PARAMS_SVH
`define UIC_ADDR_W 10
`define UIC_OFS_STATUS 10'h0c0
`define UIC_OFS_ENABLE 10'h0c2
`define UIC_OFS_CLASS 10'h0c3
`define UIC_OFS_TRIGGER 10'h0c5
`define UIC_OFS_MASKED 10'h0c6
`define UIC_OFS_VECTOR 10'h0c7
`define UIC_OFS_VSETUP 10'h0c8
`define UIC_VALID_MASK 32'hf780_407f
`define UIC_RST_WORD 32'h0000_0000
`define UIC_RST_BASE 30'h0000_0000
`define UIC_POS_DMA0 5
`define UIC_POS_ECC 17
`define UIC_POS_EXT0 25
`define UIC_POS_DIR 31
`define UIC_SYNC_W 7
`endif

// ===== hw/uic_pkg.sv
// Types shared by the interrupt controller register block.
`default_nettype none
package uic_pkg;
    typedef struct packed {
        logic [0:31] status_ff;
        logic [0:31] enable_ff;
        logic [0:31] class_ff;
        logic [0:31] trig_ff;
        logic [0:31] prev_ff;
        logic [0:29] base_ff;
        logic dir_ff;
        logic [0:31] vec_ff;
        logic crit_ff;
        logic noncrit_ff;
        logic [0:31] rdata_ff;
        logic ack_ff;
    } uic_state_t;
endpackage
`default_nettype wire

// ===== hw/uic_sync.sv
// Two-stage synchroniser for the external request pins.
`default_nettype none
module uic_sync #(
    parameter int W = 7
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    typedef struct packed {
        logic [W-1:0] s1_ff;
        logic [W-1:0] s2_ff;
    } uic_sync_st_t;

    uic_sync_st_t st_ff;
    uic_sync_st_t nxt_st;

    // The first stage feeds only the second stage.
    always_comb begin
        nxt_st.s1_ff = i_async;
        nxt_st.s2_ff = st_ff.s1_ff;
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_sync = st_ff.s2_ff;
endmodule
`default_nettype wire

// ===== tb/uic_src_model.sv
// Model of the interrupting peripherals and external request pins.
`default_nettype none
module uic_src_model (
    input wire logic i_core_clk,
    input wire logic [0:31] i_req,
    output logic [0:8] o_periph_irq,
    output logic o_ecc_irq,
    output logic [0:6] o_ext_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    // The bench moves requests on the falling edge only; following them
    // directly avoids a second falling-edge process racing the bench.
    always_comb begin
        o_periph_irq = i_req[0:8];
        o_ecc_irq = i_req[17];
        o_ext_irq = i_req[25:31];
    end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the interrupt controller register block.
`default_nettype none
`include "uic_params.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [`UIC_ADDR_W-1:0] addr = '0;
    logic rd_stb = 1'b0;
    logic wr_stb = 1'b0;
    logic [0:31] wdata = '0;
    logic [0:31] req = '0;
    logic [0:8] periph;
    logic ecc;
    logic [0:6] ext;
    logic [0:31] rdata;
    logic ack;
    logic crit;
    logic noncrit;
    int bad_count = 0;
    int total_checks = 0;
    always #5 clk = ~clk;
    uic_src_model src (.i_core_clk(clk), .i_req(req), .o_periph_irq(periph),
        .o_ecc_irq(ecc), .o_ext_irq(ext));
    uic_regs dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_dcr_addr(addr),
        .i_dcr_read(rd_stb), .i_dcr_write(wr_stb), .i_dcr_wdata(wdata),
        .i_periph_irq(periph), .i_ecc_irq(ecc), .i_ext_irq(ext),
        .o_dcr_rdata(rdata), .o_dcr_ack(ack), .o_crit_int(crit),
        .o_noncrit_int(noncrit));
    task automatic summarize();
        if (bad_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // The strobe is a single-cycle pulse; holding it longer repeats access.
    task automatic xfer(input logic w, input logic [`UIC_ADDR_W-1:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr_stb = w;
        rd_stb = ~w;
        @(negedge clk);
        q = rdata;
        chk("ack", 32'h1, {31'h0, ack});
        wr_stb = 1'b0;
        rd_stb = 1'b0;
    endtask
    task automatic wr(input logic [`UIC_ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
        chk("wr_rdata", 32'h0, q);
    endtask
    task automatic rd(input string n, input logic [`UIC_ADDR_W-1:0] a,
                      input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        chk(n, e, q);
    endtask
    task automatic ints(input logic c, input logic nc);
        chk("crit", {31'h0, c}, {31'h0, crit});
        chk("noncrit", {31'h0, nc}, {31'h0, noncrit});
    endtask
    initial begin
        #100000;
        bad_count++;
        summarize();
    end
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        ints(1'b0, 1'b0);
        rd("trig_rst", `UIC_OFS_TRIGGER, `UIC_RST_WORD);
        rd("vec_rst", `UIC_OFS_VECTOR, 32'h0);
        // Reserved bits get ones and read back zero; valid bits take the written modes.
        wr(`UIC_OFS_TRIGGER, 32'h187f_bfff);
        rd("trig_all", `UIC_OFS_TRIGGER, 32'h1000_007f);
        wr(`UIC_OFS_TRIGGER, 32'h1000_0040);
        rd("trig", `UIC_OFS_TRIGGER, 32'h1000_0040);
        wr(`UIC_OFS_ENABLE, `UIC_VALID_MASK);
        wr(`UIC_OFS_CLASS, 32'h0780_007f);
        wr(`UIC_OFS_VSETUP, 32'h4000_0000);
        rd("vset_rd", `UIC_OFS_VSETUP, 32'h0);
        req = 32'h0300_0000;
        repeat (4) @(negedge clk);
        ints(1'b1, 1'b0);
        rd("dma_stat", `UIC_OFS_STATUS, 32'h0300_0000);
        rd("vec_lo", `UIC_OFS_VECTOR, 32'h4000_0c00);
        wr(`UIC_OFS_VECTOR, 32'h1234_5678);
        rd("vec_ro", `UIC_OFS_VECTOR, 32'h4000_0c00);
        wr(`UIC_OFS_VSETUP, 32'h4000_0001);
        repeat (2) @(negedge clk);
        rd("vec_hi", `UIC_OFS_VECTOR, 32'h4000_0e00);
        req = 32'h0000_4000;
        wr(`UIC_OFS_STATUS, 32'h0300_0000);
        repeat (4) @(negedge clk);
        ints(1'b0, 1'b1);
        rd("ecc_stat", `UIC_OFS_STATUS, 32'h0000_4000);
        rd("vec_none", `UIC_OFS_VECTOR, 32'h0);
        wr(`UIC_OFS_ENABLE, 32'h0);
        repeat (3) @(negedge clk);
        ints(1'b0, 1'b0);
        wr(`UIC_OFS_ENABLE, `UIC_VALID_MASK);
        req = 32'h0000_0060;
        repeat (6) @(negedge clk);
        rd("ext_stat", `UIC_OFS_STATUS, 32'h0000_4060);
        // Both pins stay high: only the level-sensitive one may come back.
        wr(`UIC_OFS_STATUS, 32'hffff_ffff);
        repeat (4) @(negedge clk);
        rd("ext_clr", `UIC_OFS_STATUS, 32'h0000_0020);
        rd("vec_ext", `UIC_OFS_VECTOR, 32'h4000_3400);
        // Drop line 0, then raise it with line 6 high, in ascending order.
        req = 32'h0000_0021;
        repeat (4) @(negedge clk);
        req = 32'h0000_0061;
        wr(`UIC_OFS_VSETUP, 32'h4000_0000);
        repeat (6) @(negedge clk);
        rd("ext_multi", `UIC_OFS_STATUS, 32'h0000_0061);
        rd("vec_low", `UIC_OFS_VECTOR, 32'h4000_3200);
        rd("unmapped", 10'h0d0, 32'h0);
        summarize();
    end
endmodule
`default_nettype wire
